// ==== hw/sdcr_pkg.sv ====
package sdcr_pkg;

   // characters of the command and reply alphabet
   localparam logic [7:0] CH_BANG  = 8'h21;
   localparam logic [7:0] CH_QUERY = 8'h3f;
   localparam logic [7:0] CH_CR    = 8'h0d;
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_A     = 8'h41;
   localparam logic [7:0] CH_C     = 8'h43;
   localparam logic [7:0] CH_D     = 8'h44;
   localparam logic [7:0] CH_M     = 8'h4d;
   localparam logic [7:0] CH_X     = 8'h58;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_NINE  = 8'h39;

   // values after reset
   localparam logic [7:0]  ADDR_RST = 8'h30;
   localparam logic [15:0] CRC_RST  = 16'h0000;

   // crc polynomial (reflected) and character tag for encoding
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [1:0]  CRC_TAG  = 2'h1;

   // one second of measurement time in cycles
   localparam int unsigned CLK_HZ   = 125_000_000;
   localparam int unsigned TICK_S   = 1;
   localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
   localparam int unsigned PRE_W    = 27;

   // buffer sizes and limits
   localparam int unsigned CMD_MAX   = 6;
   localparam int unsigned RSP_MAX   = 8;
   localparam logic [6:0]  DLIM_M    = 7'd35;
   localparam logic [6:0]  DLIM_C    = 7'd75;
   localparam logic [6:0]  CNT_M_MAX = 7'd9;
   localparam logic [6:0]  CNT_C_MAX = 7'd99;
   localparam logic [9:0]  SECS_MAX  = 10'd999;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_HEAD = 5'b00010,
      S_DATA = 5'b00100,
      S_CRC  = 5'b01000,
      S_TAIL = 5'b10000
   } sdcr_state_t;

endpackage

// ==== hw/sdcr_crc16.sv ====
`timescale 1ns/1ps
module sdcr_crc16 (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // byte stream
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic [7:0]  din,
   // running value
   output logic      [15:0] crc
);
   import sdcr_pkg::*;

   logic [15:0] crc_ff;
   logic [15:0] nxt_crc;

   function automatic logic [15:0] step(input logic [15:0] c,
                                        input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   always_comb begin
      nxt_crc = crc_ff;
      if (clr) begin
         nxt_crc = CRC_RST;
      end else if (en) begin
         nxt_crc = step(crc_ff, din);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         crc_ff <= CRC_RST;
      end else begin
         crc_ff <= nxt_crc;
      end
   end

   assign crc = crc_ff;
endmodule

// ==== hw/sdcr_responder.sv ====
`timescale 1ns/1ps
module sdcr_responder #(
   parameter int unsigned TICK_CYC = sdcr_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // received characters
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_char,
   input  wire logic       rx_break,
   // transmitted characters
   input  wire logic       tx_ready,
   output logic            tx_valid,
   output logic      [7:0] tx_char,
   // measurement core
   output logic            meas_start,
   output logic            meas_conc,
   output logic      [3:0] meas_sel,
   output logic            meas_abort,
   input  wire logic       meas_done,
   input  wire logic [9:0] meas_secs,
   input  wire logic [6:0] meas_count,
   // value fetch
   output logic            data_req,
   output logic      [3:0] data_idx,
   input  wire logic       dat_valid,
   input  wire logic [7:0] dat_char,
   input  wire logic       dat_last,
   output logic            dat_ready,
   // status
   output logic      [7:0] sensor_addr
);
   import sdcr_pkg::*;

   typedef struct packed {
      sdcr_state_t                st;
      logic [7:0]                 addr;
      logic [2:0]                 clen;
      logic                       ovf;
      logic [CMD_MAX-1:0][7:0]    cmd;
      logic [RSP_MAX-1:0][7:0]    rsp;
      logic [3:0]                 rlen;
      logic [2:0]                 ridx;
      logic                       use_data;
      logic                       use_crc;
      logic [6:0]                 dcnt;
      logic [6:0]                 dlim;
      logic [1:0]                 cidx;
      logic                       tidx;
      logic                       m_pend;
      logic                       c_pend;
      logic                       crc_mode;
      logic                       conc_mode;
      logic                       have_res;
      logic                       srq;
      logic [9:0]                 secs;
      logic [PRE_W-1:0]           pre;
      logic                       tx_valid;
      logic [7:0]                 tx_char;
      logic                       meas_start;
      logic                       meas_conc;
      logic [3:0]                 meas_sel;
      logic                       meas_abort;
      logic                       data_req;
      logic [3:0]                 data_idx;
      logic                       dat_ready;
   } sdcr_regs_t;

   sdcr_regs_t  q_ff;
   sdcr_regs_t  nxt_q;
   logic        crc_clr;
   logic        crc_en;
   logic [7:0]  crc_byte;
   logic [15:0] crc_val;

   function automatic logic is_dig(input logic [7:0] c);
      return (c >= CH_ZERO) && (c <= CH_NINE);
   endfunction

   function automatic logic [7:0] dig(input logic [9:0] v);
      return CH_ZERO | {4'h0, v[3:0]};
   endfunction

   sdcr_crc16 u_crc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clr     (crc_clr),
      .en      (crc_en),
      .din     (crc_byte),
      .crc     (crc_val)
   );

   logic       free;
   logic       timer_run;
   logic       go;
   logic       is_meas;
   logic       wcrc;
   logic [2:0] base;
   logic [9:0] ttt;
   logic [6:0] cnt;
   logic [7:0] ch;

   always_comb begin
      nxt_q      = q_ff;
      free       = !q_ff.tx_valid || tx_ready;
      timer_run  = q_ff.secs != 10'd0;
      go         = 1'b0;
      crc_clr    = 1'b0;
      crc_en     = 1'b0;
      crc_byte   = 8'h00;
      ch         = 8'h00;
      wcrc       = (q_ff.clen >= 3'd3) && (q_ff.cmd[2] == CH_C);
      base       = wcrc ? 3'd3 : 3'd2;
      is_meas    = ((q_ff.cmd[1] == CH_M) || (q_ff.cmd[1] == CH_C)) &&
                   ((q_ff.clen == base) ||
                    ((q_ff.clen == base + 3'd1) &&
                     is_dig(q_ff.cmd[base])));
      ttt        = (meas_secs > SECS_MAX) ? SECS_MAX : meas_secs;
      cnt        = meas_count;
      nxt_q.tx_valid   = q_ff.tx_valid && !tx_ready;
      nxt_q.meas_start = 1'b0;
      nxt_q.meas_abort = 1'b0;
      nxt_q.data_req   = 1'b0;
      nxt_q.dat_ready  = 1'b0;

      // seconds countdown of the announced measurement time
      if (timer_run) begin
         if (q_ff.pre == PRE_W'(TICK_CYC - 1)) begin
            nxt_q.pre  = '0;
            nxt_q.secs = q_ff.secs - 10'd1;
         end else begin
            nxt_q.pre  = q_ff.pre + PRE_W'(1);
         end
      end

      if (meas_done) begin
         if (q_ff.m_pend) begin
            nxt_q.m_pend   = 1'b0;
            nxt_q.have_res = 1'b1;
            nxt_q.srq      = timer_run;
         end
         if (q_ff.c_pend) begin
            nxt_q.c_pend   = 1'b0;
            nxt_q.have_res = 1'b1;
         end
      end

      if (rx_break) begin
         nxt_q.clen = 3'd0;
         nxt_q.ovf  = 1'b0;
         if (q_ff.m_pend) begin
            nxt_q.m_pend     = 1'b0;
            nxt_q.srq        = 1'b0;
            nxt_q.meas_abort = 1'b1;
         end
      end else if (q_ff.st == S_IDLE && rx_valid) begin
         if (rx_char == CH_BANG) begin
            nxt_q.clen     = 3'd0;
            nxt_q.ovf      = 1'b0;
            nxt_q.rsp[0]   = q_ff.addr;
            nxt_q.rlen     = 4'd1;
            nxt_q.use_data = 1'b0;
            nxt_q.use_crc  = 1'b0;
            if (!q_ff.ovf && q_ff.clen == 3'd1 &&
                q_ff.cmd[0] == CH_QUERY) begin
               go = 1'b1;
            end else if (!q_ff.ovf && q_ff.clen != 3'd0 &&
                         q_ff.cmd[0] == q_ff.addr) begin
               if (q_ff.clen == 3'd1) begin
                  go = 1'b1;
               end else if (q_ff.cmd[1] == CH_A && q_ff.clen == 3'd3) begin
                  go           = 1'b1;
                  nxt_q.addr   = q_ff.cmd[2];
                  nxt_q.rsp[0] = q_ff.cmd[2];
               end else if (is_meas) begin
                  go                = 1'b1;
                  nxt_q.meas_start  = 1'b1;
                  nxt_q.meas_conc   = q_ff.cmd[1] == CH_C;
                  nxt_q.meas_sel    = (q_ff.clen == base) ? 4'h0 :
                                      q_ff.cmd[base][3:0];
                  nxt_q.crc_mode    = wcrc;
                  nxt_q.conc_mode   = q_ff.cmd[1] == CH_C;
                  nxt_q.have_res    = 1'b0;
                  nxt_q.srq         = 1'b0;
                  nxt_q.secs        = ttt;
                  nxt_q.pre         = '0;
                  nxt_q.rsp[1]      = dig(ttt / 10'd100);
                  nxt_q.rsp[2]      = dig((ttt / 10'd10) % 10'd10);
                  nxt_q.rsp[3]      = dig(ttt % 10'd10);
                  if (q_ff.cmd[1] == CH_C) begin
                     if (cnt > CNT_C_MAX) begin
                        cnt = CNT_C_MAX;
                     end
                     nxt_q.rsp[4] = dig({3'h0, cnt} / 10'd10);
                     nxt_q.rsp[5] = dig({3'h0, cnt} % 10'd10);
                     nxt_q.rlen   = 4'd6;
                  end else begin
                     if (cnt > CNT_M_MAX) begin
                        cnt = CNT_M_MAX;
                     end
                     nxt_q.rsp[4] = dig({3'h0, cnt});
                     nxt_q.rlen   = 4'd5;
                  end
               end else if (q_ff.cmd[1] == CH_D && q_ff.clen == 3'd3 &&
                            is_dig(q_ff.cmd[2])) begin
                  go = 1'b1;
                  if (q_ff.have_res) begin
                     nxt_q.data_req = 1'b1;
                     nxt_q.data_idx = q_ff.cmd[2][3:0];
                     nxt_q.use_data = 1'b1;
                     nxt_q.use_crc  = q_ff.crc_mode;
                     nxt_q.dcnt     = 7'd0;
                     nxt_q.dlim     = q_ff.conc_mode ? DLIM_C : DLIM_M;
                  end
               end else if (q_ff.cmd[1] == CH_X) begin
                  go = 1'b1;
               end
            end
            if (go && q_ff.c_pend && timer_run &&
                q_ff.cmd[0] != CH_QUERY) begin
               nxt_q.c_pend     = 1'b0;
               nxt_q.meas_abort = 1'b1;
            end
            if (nxt_q.meas_start) begin
               nxt_q.m_pend = !nxt_q.conc_mode;
               nxt_q.c_pend = nxt_q.conc_mode;
            end
         end else if (q_ff.clen == 3'(CMD_MAX)) begin
            nxt_q.ovf = 1'b1;
         end else begin
            nxt_q.cmd[q_ff.clen] = rx_char;
            nxt_q.clen           = q_ff.clen + 3'd1;
         end
      end else if (q_ff.st == S_IDLE && q_ff.srq && !meas_done) begin
         go             = 1'b1;
         nxt_q.srq      = 1'b0;
         nxt_q.rsp[0]   = q_ff.addr;
         nxt_q.rlen     = 4'd1;
         nxt_q.use_data = 1'b0;
         nxt_q.use_crc  = 1'b0;
      end

      if (go) begin
         nxt_q.st   = S_HEAD;
         nxt_q.ridx = 3'd0;
         nxt_q.cidx = 2'd0;
         nxt_q.tidx = 1'b0;
         crc_clr    = 1'b1;
      end

      unique case (q_ff.st)
         S_IDLE: begin
         end
         S_HEAD: begin
            if (free) begin
               ch             = q_ff.rsp[q_ff.ridx];
               nxt_q.tx_valid = 1'b1;
               nxt_q.tx_char  = ch;
               crc_en         = q_ff.use_crc;
               crc_byte       = ch;
               nxt_q.ridx     = q_ff.ridx + 3'd1;
               if ({1'b0, q_ff.ridx} == q_ff.rlen - 4'd1) begin
                  nxt_q.st = q_ff.use_data ? S_DATA :
                             (q_ff.use_crc ? S_CRC : S_TAIL);
               end
            end
         end
         S_DATA: begin
            if (q_ff.dat_ready && dat_valid) begin
               nxt_q.tx_valid = 1'b1;
               nxt_q.tx_char  = dat_char;
               crc_en         = q_ff.use_crc;
               crc_byte       = dat_char;
               nxt_q.dcnt     = q_ff.dcnt + 7'd1;
               if (dat_last || q_ff.dcnt + 7'd1 == q_ff.dlim) begin
                  nxt_q.st = q_ff.use_crc ? S_CRC : S_TAIL;
               end
            end
         end
         S_CRC: begin
            if (free) begin
               nxt_q.tx_valid = 1'b1;
               nxt_q.cidx     = q_ff.cidx + 2'd1;
               unique case (q_ff.cidx)
                  2'd0:    nxt_q.tx_char = {CRC_TAG, 2'h0, crc_val[15:12]};
                  2'd1:    nxt_q.tx_char = {CRC_TAG, crc_val[11:6]};
                  default: nxt_q.tx_char = {CRC_TAG, crc_val[5:0]};
               endcase
               if (q_ff.cidx == 2'd2) begin
                  nxt_q.st = S_TAIL;
               end
            end
         end
         S_TAIL: begin
            if (free) begin
               nxt_q.tx_valid = 1'b1;
               nxt_q.tx_char  = q_ff.tidx ? CH_LF : CH_CR;
               nxt_q.tidx     = 1'b1;
               if (q_ff.tidx) begin
                  nxt_q.st = S_IDLE;
               end
            end
         end
      endcase

      if (nxt_q.st == S_DATA && !nxt_q.tx_valid) begin
         nxt_q.dat_ready = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_ff      <= '0;
         q_ff.st   <= S_IDLE;
         q_ff.addr <= ADDR_RST;
      end else begin
         q_ff      <= nxt_q;
      end
   end

   assign tx_valid    = q_ff.tx_valid;
   assign tx_char     = q_ff.tx_char;
   assign meas_start  = q_ff.meas_start;
   assign meas_conc   = q_ff.meas_conc;
   assign meas_sel    = q_ff.meas_sel;
   assign meas_abort  = q_ff.meas_abort;
   assign data_req    = q_ff.data_req;
   assign data_idx    = q_ff.data_idx;
   assign dat_ready   = q_ff.dat_ready;
   assign sensor_addr = q_ff.addr;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic bang_idle;
   assign bang_idle = q_ff.st == S_IDLE && rx_valid && !rx_break &&
                      rx_char == CH_BANG && !q_ff.ovf;

   sequence s_m_reply;
      q_ff.rlen == 4'd5 && is_dig(q_ff.rsp[4]) && q_ff.st == S_HEAD;
   endsequence

   sequence s_c_reply;
      q_ff.rlen == 4'd6 && is_dig(q_ff.rsp[4]) && is_dig(q_ff.rsp[5]);
   endsequence

   chk_query_reply: assert property (
      bang_idle && q_ff.clen == 3'd1 && q_ff.cmd[0] == CH_QUERY
      |=> q_ff.st == S_HEAD && q_ff.rlen == 4'd1 &&
          q_ff.rsp[0] == $past(q_ff.addr))
      else $error("address query reply wrong");

   chk_addr_change: assert property (
      bang_idle && q_ff.clen == 3'd3 && q_ff.cmd[0] == q_ff.addr &&
      q_ff.cmd[1] == CH_A
      |=> q_ff.addr == $past(q_ff.cmd[2]) && q_ff.rsp[0] == q_ff.addr)
      else $error("address not changed");

   chk_foreign_addr: assert property (
      bang_idle && q_ff.clen != 3'd0 && q_ff.cmd[0] != q_ff.addr &&
      q_ff.cmd[0] != CH_QUERY && !q_ff.srq
      |=> q_ff.st == S_IDLE && !q_ff.meas_start && !q_ff.data_req)
      else $error("foreign command answered");

   chk_m_count: assert property (
      q_ff.meas_start && !q_ff.meas_conc |-> s_m_reply)
      else $error("measure reply malformed");

   chk_c_count: assert property (
      q_ff.meas_start && q_ff.meas_conc |-> s_c_reply ##1 !q_ff.srq)
      else $error("concurrent reply malformed");

   chk_no_conc_srq: assert property (
      meas_done && q_ff.c_pend && !q_ff.m_pend && !q_ff.srq
      |=> !q_ff.srq)
      else $error("service request after concurrent");

   chk_srq_raise: assert property (
      meas_done && q_ff.m_pend && timer_run && !rx_break && !bang_idle
      |=> q_ff.srq)
      else $error("service request missing");

   chk_srq_send: assert property (
      q_ff.st == S_IDLE && q_ff.srq && !rx_valid && !rx_break && !meas_done
      |=> q_ff.st == S_HEAD && q_ff.rlen == 4'd1 && q_ff.rsp[0] == q_ff.addr)
      else $error("service request not sent");

   chk_break_abort: assert property (
      rx_break && q_ff.m_pend |=> !q_ff.m_pend && q_ff.meas_abort)
      else $error("break did not abandon measure");

   chk_conc_abort: assert property (
      go && bang_idle && q_ff.c_pend && timer_run &&
      q_ff.cmd[0] == q_ff.addr
      |=> q_ff.meas_abort)
      else $error("concurrent not aborted");

   chk_data_limit: assert property (
      q_ff.st == S_DATA |-> q_ff.dcnt < q_ff.dlim &&
      (q_ff.dlim == (q_ff.conc_mode ? DLIM_C : DLIM_M)))
      else $error("value data over limit");

   chk_crc_chars: assert property (
      q_ff.st == S_CRC && free |=> q_ff.tx_valid &&
      q_ff.tx_char[7:6] == CRC_TAG && q_ff.use_crc)
      else $error("crc character wrong");

   chk_tail_order: assert property (
      q_ff.st == S_TAIL && !q_ff.tidx && free
      |=> q_ff.tx_char == CH_CR && q_ff.tidx)
      else $error("terminator order wrong");

endmodule

// ==== testbench/sdcr_logger.sv ====
`timescale 1ns/1ps
module sdcr_logger (
   // clock
   input  wire logic       sys_clk,
   // command side
   output logic            rx_valid,
   output logic      [7:0] rx_char,
   output logic            rx_break,
   // reply side
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_char,
   output logic            tx_ready
);
   logic [7:0] got[$];
   logic       stall = 1'b0;

   initial begin
      rx_valid = 1'b0;
      rx_char  = 8'h00;
      rx_break = 1'b0;
      tx_ready = 1'b0;
   end

   // prompt reader, or one that takes every other cycle
   always @(posedge sys_clk) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_char);
      tx_ready <= stall ? ~tx_ready : 1'b1;
   end

   task automatic pulse_break();
      @(posedge sys_clk);
      rx_break <= 1'b1;
      @(posedge sys_clk);
      rx_break <= 1'b0;
   endtask

   task automatic send(input string s);
      pulse_break();
      foreach (s[i]) begin
         rx_valid <= 1'b1;
         rx_char  <= s[i];
         @(posedge sys_clk);
      end
      rx_valid <= 1'b0;
      // idle line shows no stale character
      rx_char  <= ~rx_char;
   endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
   import sdcr_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        rx_valid, rx_break, tx_ready, tx_valid;
   logic  [7:0] rx_char, tx_char, sensor_addr;
   logic  [7:0] dat_char = 8'h00;
   logic        meas_start, meas_conc, meas_abort, data_req, dat_ready;
   logic        meas_done = 1'b0;
   logic        dat_valid = 1'b0;
   logic        dat_last = 1'b0;
   logic  [3:0] meas_sel, data_idx, last_idx;
   logic  [9:0] meas_secs = 10'h001;
   logic  [6:0] meas_count = 7'h00;
   logic [31:0] seed = 32'ha158ab69;
   int          mismatches = 0;
   int          check_count = 0;
   int          nreq = 0;
   int          nabort = 0;
   int          nstart = 0;
   int          vi = 0;
   bit          act = 1'b0;
   string       vals = "+1";

   always #4 sys_clk = ~sys_clk;

   sdcr_responder #(.TICK_CYC(10)) i_sdcr_responder (
      .sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid),
      .rx_char(rx_char), .rx_break(rx_break), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_char(tx_char), .meas_start(meas_start),
      .meas_conc(meas_conc), .meas_sel(meas_sel),
      .meas_abort(meas_abort), .meas_done(meas_done),
      .meas_secs(meas_secs), .meas_count(meas_count),
      .data_req(data_req), .data_idx(data_idx), .dat_valid(dat_valid),
      .dat_char(dat_char), .dat_last(dat_last), .dat_ready(dat_ready),
      .sensor_addr(sensor_addr));

   sdcr_logger i_sdcr_logger (
      .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_char(rx_char),
      .rx_break(rx_break), .tx_valid(tx_valid), .tx_char(tx_char),
      .tx_ready(tx_ready));

   // measurement core: streams vals on each data request
   always @(posedge sys_clk) begin
      if (meas_abort)
         nabort++;
      if (meas_start)
         nstart++;
      if (data_req) begin
         vi = 0;
         act = 1'b1;
         nreq++;
         last_idx <= data_idx;
      end else if (dat_valid && dat_ready) begin
         vi++;
         act = vi < vals.len();
      end
      dat_valid <= act;
      dat_char  <= act ? vals[vi] : ~dat_char;
      dat_last  <= act && vi == vals.len() - 1;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic string ann(input int s, input int c, input bit conc);
      if (s > 999)
         s = 999;
      if (c > (conc ? 99 : 9))
         c = conc ? 99 : 9;
      if (conc)
         return $sformatf("5%03d%02d\015\n", s, c);
      return $sformatf("5%03d%0d\015\n", s, c);
   endfunction

   function automatic string crc3(input string s);
      logic [15:0] c;
      c = 16'h0000;
      foreach (s[i]) begin
         c = c ^ {8'h00, s[i]};
         repeat (8)
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return $sformatf("%c%c%c", {4'h4, c[15:12]}, {2'h1, c[11:6]},
                       {2'h1, c[5:0]});
   endfunction

   function automatic string drep(input string v, input bit crc);
      string r;
      r = {"5", v};
      if (crc)
         r = {r, crc3(r)};
      return {r, "\015\n"};
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check_str(input string name, input string e, input string g);
      check_count++;
      if (e != g) begin
         mismatches++;
         $display("BAD %s expected %s seen %s", name, e, g);
      end
   endtask

   task automatic check_v(input string name, input logic [31:0] e,
                          input logic [31:0] g);
      check_count++;
      if (e !== g) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic expect_reply(input string name, input string e);
      string seen;
      int n;
      seen = "";
      for (n = 0; n < 4000 && i_sdcr_logger.got.size() < e.len(); n++)
         @(posedge sys_clk);
      if (n == 4000) begin
         mismatches++;
         wrap_up();
      end
      repeat (24) @(posedge sys_clk);
      while (i_sdcr_logger.got.size() > 0)
         seen = {seen, $sformatf("%c", i_sdcr_logger.got.pop_front())};
      check_str(name, e, seen);
   endtask

   task automatic done_pulse();
      @(posedge sys_clk);
      meas_done <= 1'b1;
      @(posedge sys_clk);
      meas_done <= 1'b0;
   endtask

   initial begin
      string e, cmd;
      int s, c, n0, lim;
      bit conc, crc;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      i_sdcr_logger.send("0D0!");
      expect_reply("empty data", "0\015\n");
      check_v("data requests", 0, nreq);
      i_sdcr_logger.send("0!");
      expect_reply("acknowledge", "0\015\n");
      i_sdcr_logger.send("?!");
      expect_reply("query", "0\015\n");
      i_sdcr_logger.send("0A5!");
      expect_reply("new address", "5\015\n");
      check_v("address", 8'h35, sensor_addr);
      i_sdcr_logger.send("0!");
      expect_reply("foreign address", "");
      i_sdcr_logger.send("?!");
      expect_reply("query", "5\015\n");
      i_sdcr_logger.stall = 1'b1;
      for (int k = 0; k < 4; k++) begin
         conc = k[0];
         crc = k[1];
         s = rnd() % 1000 + 24;
         c = rnd() % 128;
         meas_secs <= s[9:0];
         meas_count <= c[6:0];
         cmd = conc ? "5C" : "5M";
         if (crc)
            cmd = {cmd, "C"};
         i_sdcr_logger.send({cmd, "3!"});
         expect_reply("announce", ann(s, c, conc));
         check_v("select", 3, meas_sel);
         check_v("kind", conc, meas_conc);
         check_v("starts", k + 1, nstart);
         done_pulse();
         e = "";
         if (!conc)
            e = "5\015\n";
         expect_reply("service request", e);
         if (conc)
            repeat ((s > 999 ? 999 : s) * 10) @(posedge sys_clk);
         vals = "";
         for (int j = rnd() % 90; j >= 0; j--)
            vals = {vals, $sformatf("%c", vals.len() % 4 ?
                    48 + rnd() % 10 : 43 + 2 * (rnd() % 2))};
         lim = conc ? 75 : 35;
         e = vals.substr(0, (vals.len() > lim ? lim : vals.len()) - 1);
         i_sdcr_logger.send("5D0!");
         expect_reply("data", drep(e, crc));
         check_v("no new start", k + 1, nstart);
      end
      vals = "+7";
      for (int i = 1; i < 10; i++) begin
         i_sdcr_logger.send($sformatf("5D%0d!", i));
         expect_reply("indexed data", drep(vals, 1'b1));
         check_v("index", i, last_idx);
      end
      meas_secs <= 10'h032;
      n0 = nabort;
      i_sdcr_logger.send("5C!");
      expect_reply("announce", ann(50, meas_count, 1'b1));
      i_sdcr_logger.send("5!");
      expect_reply("acknowledge", "5\015\n");
      check_v("abort count", n0 + 1, nabort);
      i_sdcr_logger.send("5M!");
      expect_reply("announce", ann(50, meas_count, 1'b0));
      i_sdcr_logger.pulse_break();
      done_pulse();
      expect_reply("aborted service request", "");
      check_v("abort count", n0 + 2, nabort);
      i_sdcr_logger.send("5XABCDEF!");
      expect_reply("overlong", "");
      i_sdcr_logger.send("5XAB!");
      expect_reply("extended", "5\015\n");
      wrap_up();
   end
endmodule
